// ==== tphdu_pkg.sv ====
// Shared constants and types for the timer paced half duplex serial port.
package tphdu_pkg;
  localparam int PER_W_DEF = 10;
  localparam int PRE_W = 10;
  localparam int DIV_W = 3;
  localparam int ADR_W = 5;
  localparam int CH_TX = 0;
  localparam int CH_RX = 1;
  localparam logic [ADR_W-1:0] OFF_CP [2] = '{5'h00, 5'h08};
  localparam logic [ADR_W-1:0] OFF_WC [2] = '{5'h04, 5'h0c};
  localparam logic [ADR_W-1:0] OFF_CFG = 5'h10;
  localparam logic [ADR_W-1:0] OFF_STAT = 5'h14;
  localparam logic [ADR_W-1:0] OFF_TXD = 5'h18;
  localparam int CB_DIV_LO = 0;
  localparam int CB_DIV_HI = 2;
  localparam int CB_EN = 3;
  localparam int CB_DIR = 6;
  localparam int CB_DATA = 7;
  localparam int CB_LOAD = 8;
  localparam int CB_PERIOD_IRQ_ENABLE = 9;
  localparam logic [15:0] CTRL_WMASK = 16'h0eff;
  localparam logic [15:0] CTRL_RST [2] = '{16'h00c0, 16'h0000};
  localparam logic [15:0] PER_RST = 16'h0341;
  localparam logic [15:0] WID_RST = 16'h0000;
  localparam logic [PRE_W-1:0] PRE_BASE = 10'h004;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int CFG_W = 5;
  localparam int CFG_FALL = 0;
  localparam int CFG_FIE_LO = 1;
  localparam int CFG_FIE_HI = 3;
  localparam int CFG_FE = 4;
  localparam logic [CFG_W-1:0] CFG_RST = 5'h00;
  localparam int ST_RXV = 8;
  localparam int ST_PND_LO = 11;
  localparam int ST_PND_HI = 13;
  localparam int ST_FERR = 14;
  localparam int ST_SPIKE = 15;
  localparam logic [31:0] VEC_BASE = 32'h3000_0000;
  localparam logic [31:0] VEC_FAST_OFF = 32'h0000_002c;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tphdu_tx_st_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} tphdu_rx_st_t;
endpackage

// ==== tphdu_tmr_if.sv ====
// Signals between the register file and one timer channel.
`timescale 1ns/1ns
`default_nettype none
interface tphdu_tmr_if
  import tphdu_pkg::*;
#(
  parameter int PER_W = PER_W_DEF
) ();
  logic en;
  logic load;
  logic [DIV_W-1:0] presc;
  logic [PER_W-1:0] period;
  logic half;
  logic [PER_W-1:0] count;
  logic tick;
  modport ctl (output en, load, presc, period, half, input count, tick);
  modport tmr (input en, load, presc, period, half, output count, tick);
endinterface
`default_nettype wire

// ==== tphdu_timer.sv ====
// One bit rate timer channel with pre-divider and period counter.
`timescale 1ns/1ns
`default_nettype none
module tphdu_timer
  import tphdu_pkg::*;
#(
  parameter int PER_W = PER_W_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  tphdu_tmr_if.tmr t
);
  logic [PRE_W-1:0] pre_r, pre_nxt, pre_top;
  logic [PER_W-1:0] cnt_r, cnt_nxt, act_r, act_nxt, lim;
  logic tick_r, tick_nxt;

  always_comb begin
    // RL1 divide by four shl
    pre_top = (PRE_BASE << t.presc) - 1'b1;
    lim = t.half ? (act_r >> 1) : act_r;
    if (lim == '0) begin
      lim = PER_W'(1);
    end
    pre_nxt = pre_r;
    cnt_nxt = cnt_r;
    act_nxt = act_r;
    tick_nxt = 1'b0;
    // RL8 load restarts period
    if (!t.en || t.load) begin
      pre_nxt = '0;
      cnt_nxt = '0;
      act_nxt = t.period;
    end else if (pre_r >= pre_top) begin
      pre_nxt = '0;
      // RL2 one reference step
      if (cnt_r >= lim - 1'b1) begin
        cnt_nxt = '0;
        act_nxt = t.period;
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end else begin
      pre_nxt = pre_r + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_r <= '0;
      cnt_r <= '0;
      act_r <= PER_W'(PER_RST);
      tick_r <= 1'b0;
    end else begin
      pre_r <= pre_nxt;
      cnt_r <= cnt_nxt;
      act_r <= act_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign t.count = cnt_r;
  assign t.tick = tick_r;

  sequence s_run_div4;
    (t.en && !t.load && t.presc == 3'h0) [*4];
  endsequence

  div_four_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL1
    (pre_r == '0) ##0 s_run_div4 |=> pre_r == '0)
    else $error("Divide by four reference step wrong.");

  tick_gap_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL2
    t.tick |=> !t.tick [*3])
    else $error("Timer ticks closer than one reference step.");

  load_restart_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL8
    t.en && t.load |=> cnt_r == '0 && !t.tick)
    else $error("Load did not restart the period.");
endmodule
`default_nettype wire

// ==== tphdu_top.sv ====
// Timer paced half duplex serial port with Wishbone register access.
// Function
// RL1 - Prescale code 000 divides by 4, 001 by 8.
// RL2 - Counter steps once per reference clock.
// RL3 - Period value sets bit time; 833 default.
// RL4 - Period and width keep ten writable bits.
// RL5 - Software keeps width below period.
// RL6 - Each channel: control, period, width, count.
// RL7 - One 32-bit write updates two registers.
// RL8 - Load bit makes new period take effect.
// RL9 - Frame: start, eight data, stop bits.
// RL10 - Transmit line idles high.
// RL11 - Control bit 7 drives idle transmit pin.
// RL12 - Receive timer flags each period completion.
// RL13 - Receive waits half bit, then full bits.
// RL14 - Receive input senses falling edges.
// RL15 - Fast vector at base plus 0x2C.
// RL16 - Fast enables per receive, transmit, edge.
// RL17 - Irq enable flags every completed period.
// RL18 - Mid start high means spike, discard.
// RL19 - Receive accepted only while not transmitting.
// RL20 - Data sent least significant bit first.
// RL21 - Transmitter stops counter, line high, after stop.
`timescale 1ns/1ns
`default_nettype none
module tphdu_top
  import tphdu_pkg::*;
#(
  parameter int PER_W = PER_W_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rx_i,
  output logic tx_o,
  output logic tx_oe_n_o,
  output logic fast_irq_o,
  output logic [31:0] fast_vec_addr_o
);
  if (PER_W < 2 || PER_W > 16) begin : g_bad_per
    $error("PER_W must lie between 2 and 16.");
  end

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] val, input logic [1:0] sel);
    merge16 = {sel[1] ? val[15:8] : old[15:8], sel[0] ? val[7:0] : old[7:0]};
  endfunction

  tphdu_tmr_if #(.PER_W(PER_W)) txt ();
  tphdu_tmr_if #(.PER_W(PER_W)) rxt ();

  logic [15:0] ctrl_r [2], ctrl_nxt [2];
  logic [PER_W-1:0] per_r [2], per_nxt [2], wid_r [2], wid_nxt [2], cnt [2];
  logic [1:0] load_r, load_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic ack_r, ack_nxt;
  logic [CFG_W-1:0] cfg_r, cfg_nxt;
  logic [2:0] pnd_r, pnd_nxt;
  logic rxv_r, rxv_nxt, ferr_r, ferr_nxt, spk_r, spk_nxt, irq_r, irq_nxt, irq_src;
  logic [15:0] stat, clr;
  logic req, wr, tx_go, tx_done, rx_go, rx_stop, rx_spike, rx_ok, rx_ferr, fall;
  tphdu_tx_st_t tx_st_r, tx_st_nxt;
  tphdu_rx_st_t rx_st_r, rx_st_nxt;
  logic [7:0] tx_sh_r, tx_sh_nxt, rx_sh_r, rx_sh_nxt, rxd_r, rxd_nxt;
  logic [2:0] tx_idx_r, tx_idx_nxt, rx_idx_r, rx_idx_nxt;
  logic tx_line_r, tx_line_nxt, rx_half_r, rx_half_nxt;
  logic rx_meta_r, rx_sync_r, rx_prev_r;

  tphdu_timer #(.PER_W(PER_W)) u_txt (.clk_i(clk_i), .rst_i(rst_i), .t(txt.tmr));
  tphdu_timer #(.PER_W(PER_W)) u_rxt (.clk_i(clk_i), .rst_i(rst_i), .t(rxt.tmr));

  assign txt.en = ctrl_r[CH_TX][CB_EN];
  assign txt.load = load_r[CH_TX];
  assign txt.presc = ctrl_r[CH_TX][CB_DIV_HI:CB_DIV_LO];
  assign txt.period = per_r[CH_TX];
  assign txt.half = 1'b0;
  assign rxt.en = ctrl_r[CH_RX][CB_EN];
  assign rxt.load = load_r[CH_RX];
  assign rxt.presc = ctrl_r[CH_RX][CB_DIV_HI:CB_DIV_LO];
  assign rxt.period = per_r[CH_RX];
  assign rxt.half = rx_half_r;
  assign cnt[CH_TX] = txt.count;
  assign cnt[CH_RX] = rxt.count;

  assign req = wb_cyc_i && wb_stb_i;
  assign wr = req && wb_we_i && ack_r;
  assign tx_go = wr && wb_adr_i == OFF_TXD && wb_sel_i[0] && tx_st_r == TX_IDLE;
  assign tx_done = tx_st_r == TX_STOP && txt.tick;
  // RL14 falling edge detect
  assign fall = rx_prev_r && !rx_sync_r;
  // RL19 only while not transmitting
  assign rx_go = rx_st_r == RX_IDLE && fall && cfg_r[CFG_FALL] && tx_st_r == TX_IDLE;
  // RL18 spike check mid start
  assign rx_spike = rx_st_r == RX_START && rxt.tick && rx_sync_r;
  assign rx_ok = rx_st_r == RX_STOP && rxt.tick && rx_sync_r;
  assign rx_ferr = rx_st_r == RX_STOP && rxt.tick && !rx_sync_r;
  assign rx_stop = rx_spike || (rx_st_r == RX_STOP && rxt.tick);
  assign stat = {spk_r, ferr_r, pnd_r, rx_st_r != RX_IDLE, tx_st_r != TX_IDLE, rxv_r, rxd_r};

  // Register file and bus slave.
  always_comb begin
    logic [15:0] v;
    logic [1:0] ld;
    v = '0;
    ld = '0;
    ack_nxt = req && !ack_r;
    dat_nxt = dat_r;
    cfg_nxt = cfg_r;
    for (int c = 0; c < 2; c++) begin
      ctrl_nxt[c] = ctrl_r[c];
      per_nxt[c] = per_r[c];
      wid_nxt[c] = wid_r[c];
      // RL7 two halves per word
      if (wr && wb_adr_i == OFF_CP[c]) begin
        v = merge16(ctrl_r[c], wb_dat_i[15:0], wb_sel_i[1:0]);
        ld[c] = v[CB_LOAD];
        ctrl_nxt[c] = v & CTRL_WMASK;
        // RL4 ten writable bits
        per_nxt[c] = PER_W'(merge16(16'(per_r[c]), wb_dat_i[31:16], wb_sel_i[3:2]));
      end
      if (wr && wb_adr_i == OFF_WC[c]) begin
        wid_nxt[c] = PER_W'(merge16(16'(wid_r[c]), wb_dat_i[15:0], wb_sel_i[1:0]));
      end
    end
    if (tx_go) begin
      ctrl_nxt[CH_TX][CB_EN] = 1'b1;
      ld[CH_TX] = 1'b1;
    end
    // RL21 stop counter, line high
    if (tx_done) begin
      ctrl_nxt[CH_TX][CB_EN] = 1'b0;
      ctrl_nxt[CH_TX][CB_DATA] = 1'b1;
    end
    if (rx_go) begin
      ctrl_nxt[CH_RX][CB_EN] = 1'b1;
      ld[CH_RX] = 1'b1;
    end
    if (rx_stop) begin
      ctrl_nxt[CH_RX][CB_EN] = 1'b0;
    end
    load_nxt = ld;
    if (wr && wb_adr_i == OFF_CFG && wb_sel_i[0]) begin
      cfg_nxt = wb_dat_i[CFG_W-1:0];
    end
    clr = (wr && wb_adr_i == OFF_STAT && wb_sel_i[1]) ? wb_dat_i[15:0] : '0;
    rxv_nxt = (rxv_r && !clr[ST_RXV]) || rx_ok;
    ferr_nxt = (ferr_r && !clr[ST_FERR]) || rx_ferr;
    spk_nxt = (spk_r && !clr[ST_SPIKE]) || rx_spike;
    // RL17 period flags gated
    pnd_nxt = (pnd_r & ~clr[ST_PND_HI:ST_PND_LO])
      | {fall && cfg_r[CFG_FALL], txt.tick && ctrl_r[CH_TX][CB_PERIOD_IRQ_ENABLE], rxt.tick && ctrl_r[CH_RX][CB_PERIOD_IRQ_ENABLE]};
    // RL16 per source enables
    irq_src = cfg_r[CFG_FE] && |(pnd_r & cfg_r[CFG_FIE_HI:CFG_FIE_LO]);
    irq_nxt = irq_src;
    if (req && !ack_r) begin
      dat_nxt = '0;
      // RL6 four registers each
      for (int c = 0; c < 2; c++) begin
        if (wb_adr_i == OFF_CP[c]) begin
          dat_nxt = {16'(per_r[c]), ctrl_r[c]};
        end
        if (wb_adr_i == OFF_WC[c]) begin
          dat_nxt = {16'(cnt[c]), 16'(wid_r[c])};
        end
      end
      if (wb_adr_i == OFF_CFG) begin
        dat_nxt = 32'(cfg_r);
      end
      if (wb_adr_i == OFF_STAT) begin
        dat_nxt = 32'(stat);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int c = 0; c < 2; c++) begin
        ctrl_r[c] <= CTRL_RST[c];
        // RL3 default period
        per_r[c] <= PER_W'(PER_RST);
        wid_r[c] <= PER_W'(WID_RST);
      end
      load_r <= '0;
      dat_r <= '0;
      ack_r <= 1'b0;
      cfg_r <= CFG_RST;
      pnd_r <= '0;
      rxv_r <= 1'b0;
      ferr_r <= 1'b0;
      spk_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      per_r <= per_nxt;
      wid_r <= wid_nxt;
      load_r <= load_nxt;
      dat_r <= dat_nxt;
      ack_r <= ack_nxt;
      cfg_r <= cfg_nxt;
      pnd_r <= pnd_nxt;
      rxv_r <= rxv_nxt;
      ferr_r <= ferr_nxt;
      spk_r <= spk_nxt;
      irq_r <= irq_nxt;
    end
  end

  // Transmit engine.
  always_comb begin
    tx_st_nxt = tx_st_r;
    tx_sh_nxt = tx_sh_r;
    tx_idx_nxt = tx_idx_r;
    // RL9 start, data, stop
    unique case (tx_st_r)
      TX_IDLE: begin
        if (tx_go) begin
          tx_st_nxt = TX_START;
          tx_sh_nxt = wb_dat_i[7:0];
        end
      end
      TX_START: begin
        if (txt.tick) begin
          tx_st_nxt = TX_DATA;
          tx_idx_nxt = '0;
        end
      end
      TX_DATA: begin
        // RL20 shift out low first
        if (txt.tick && tx_idx_r == LAST_BIT) begin
          tx_st_nxt = TX_STOP;
        end else if (txt.tick) begin
          tx_idx_nxt = tx_idx_r + 1'b1;
          tx_sh_nxt = tx_sh_r >> 1;
        end
      end
      TX_STOP: begin
        if (txt.tick) begin
          tx_st_nxt = TX_IDLE;
        end
      end
    endcase
    // RL11 idle pin from control
    unique case (tx_st_nxt)
      TX_IDLE: tx_line_nxt = ctrl_nxt[CH_TX][CB_DATA];
      TX_START: tx_line_nxt = 1'b0;
      TX_DATA: tx_line_nxt = tx_sh_nxt[0];
      TX_STOP: tx_line_nxt = 1'b1;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_st_r <= TX_IDLE;
      tx_sh_r <= '0;
      tx_idx_r <= '0;
      tx_line_r <= 1'b1;
    end else begin
      tx_st_r <= tx_st_nxt;
      tx_sh_r <= tx_sh_nxt;
      tx_idx_r <= tx_idx_nxt;
      tx_line_r <= tx_line_nxt;
    end
  end

  // Receive engine with input synchroniser.
  always_comb begin
    rx_st_nxt = rx_st_r;
    rx_sh_nxt = rx_sh_r;
    rx_idx_nxt = rx_idx_r;
    rx_half_nxt = rx_half_r;
    rxd_nxt = rxd_r;
    unique case (rx_st_r)
      RX_IDLE: begin
        // RL13 half bit first
        if (rx_go) begin
          rx_st_nxt = RX_START;
          rx_half_nxt = 1'b1;
        end
      end
      RX_START: begin
        if (rx_spike) begin
          rx_st_nxt = RX_IDLE;
          rx_half_nxt = 1'b0;
        end else if (rxt.tick) begin
          rx_st_nxt = RX_DATA;
          rx_half_nxt = 1'b0;
          rx_idx_nxt = '0;
        end
      end
      RX_DATA: begin
        // RL12 sample each period
        if (rxt.tick) begin
          rx_sh_nxt = {rx_sync_r, rx_sh_r[7:1]};
          rx_idx_nxt = rx_idx_r + 1'b1;
          if (rx_idx_r == LAST_BIT) begin
            rx_st_nxt = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (rxt.tick) begin
          rx_st_nxt = RX_IDLE;
        end
        if (rx_ok) begin
          rxd_nxt = rx_sh_r;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
      rx_prev_r <= 1'b1;
      rx_st_r <= RX_IDLE;
      rx_sh_r <= '0;
      rx_idx_r <= '0;
      rx_half_r <= 1'b0;
      rxd_r <= '0;
    end else begin
      rx_meta_r <= rx_i;
      rx_sync_r <= rx_meta_r;
      rx_prev_r <= rx_sync_r;
      rx_st_r <= rx_st_nxt;
      rx_sh_r <= rx_sh_nxt;
      rx_idx_r <= rx_idx_nxt;
      rx_half_r <= rx_half_nxt;
      rxd_r <= rxd_nxt;
    end
  end

  assign wb_dat_o = dat_r;
  assign wb_ack_o = ack_r;
  // RL10 line idles high
  assign tx_o = tx_line_r;
  assign tx_oe_n_o = ~ctrl_r[CH_TX][CB_DIR];
  assign fast_irq_o = irq_r;
  // RL15 fast autovector address
  assign fast_vec_addr_o = VEC_BASE + VEC_FAST_OFF;

  sequence s_req_new;
    req && !ack_r;
  endsequence

  wb_ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL7
    s_req_new ##1 wb_ack_o |=> !wb_ack_o)
    else $error("Ack held longer than one cycle.");
  idle_line_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL11
    tx_st_r == TX_IDLE |-> tx_o == ctrl_r[CH_TX][CB_DATA])
    else $error("Idle line differs from control pin bit.");
  start_low_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL9
    tx_go |=> !tx_o && ctrl_r[CH_TX][CB_EN] && load_r[CH_TX])
    else $error("Start bit not driven low with timer restart.");
  lsb_first_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL20
    tx_st_r == TX_START && txt.tick |=> tx_o == $past(tx_sh_r[0]))
    else $error("First data bit is not the lowest bit.");
  tx_stop_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL21
    tx_done |=> tx_st_r == TX_IDLE && !ctrl_r[CH_TX][CB_EN] && tx_o)
    else $error("Transmitter not stopped with line high.");
  half_duplex_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL19
    $rose(rx_st_r != RX_IDLE) |-> $past(tx_st_r) == TX_IDLE)
    else $error("Reception started during transmission.");
  rx_half_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL13
    rx_go |=> rx_half_r ##0 (rx_half_r throughout (rx_st_r == RX_START)))
    else $error("First receive period is not a half bit.");
  spike_drop_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL18
    rx_spike |=> rx_st_r == RX_IDLE && spk_r && (!rxv_r || $past(rxv_r)))
    else $error("Spike not discarded.");
  rx_flag_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL12
    rxt.tick && ctrl_r[CH_RX][CB_PERIOD_IRQ_ENABLE] |=> pnd_r[0])
    else $error("Receive period flag not raised.");
  irq_gate_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL16
    fast_irq_o == $past(irq_src))
    else $error("Interrupt raised without an enabled source.");
endmodule
`default_nettype wire

// ==== tphdu_remote.sv ====
// Remote serial device model that sends frames and checks received frames.
`timescale 1ns/1ns
`default_nettype none
module tphdu_remote (
  input wire logic clk_i,
  input wire logic line_i,
  output logic line_o
);
  initial begin
    line_o = 1'b1;
  end

  task automatic send(input logic [7:0] b, input int d, input int spike, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    if (spike > 0) begin
      @(posedge clk_i);
      line_o <= 1'b0;
      repeat (spike) @(posedge clk_i);
      line_o <= 1'b1;
    end else begin
      for (int i = 0; i < 10; i++) begin
        @(posedge clk_i);
        line_o <= f[i];
        repeat (d - 1) @(posedge clk_i);
      end
      @(posedge clk_i);
      line_o <= 1'b1;
    end
  endtask

  task automatic take(input int d, output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    b = 8'h00;
    while (line_i !== 1'b0 && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    repeat (d / 2) @(posedge clk_i);
    ok = (line_i === 1'b0);
    for (int i = 0; i < 8; i++) begin
      repeat (d) @(posedge clk_i);
      b[i] = line_i;
    end
    repeat (d) @(posedge clk_i);
    ok = ok && (line_i === 1'b1);
  endtask
endmodule
`default_nettype wire

// ==== tphdu_top_tb.sv ====
// Self-checking bench for the timer paced serial port.
`timescale 1ns/1ns
`default_nettype none
module tphdu_top_tb
  import tphdu_pkg::*;
;
  logic clk_i, rst_i, cyc, stb, we, rx, tx, oe_n, firq, ack, ok;
  logic [ADR_W-1:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, vec, rd;
  logic [7:0] got;
  logic [7:0] tbyte [2] = '{8'ha5, 8'h3c};
  int miscompares, samples_checked, d;

  tphdu_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .rx_i(rx), .tx_o(tx), .tx_oe_n_o(oe_n), .fast_irq_o(firq), .fast_vec_addr_o(vec));
  tphdu_remote rem (.clk_i(clk_i), .line_i(tx), .line_o(rx));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic wb(input logic [ADR_W-1:0] a, input logic w, input logic [31:0] dt, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= dt;
    sel <= s;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 100) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    end
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    wb(OFF_STAT, 1'b0, 32'h0, 4'hf);
    while (rd[b] !== v && n < 400) begin
      wb(OFF_STAT, 1'b0, 32'h0, 4'hf);
      n++;
    end
    if (n >= 400) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, rd[b], v);
    end
  endtask

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk_i);
    miscompares++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    close_out();
  end

  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 5'h00;
    sel = 4'h0;
    wdat = 32'h0;
    miscompares = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(OFF_CP[CH_TX], 1'b0, 32'h0, 4'hf);
    chk(rd, 32'h0341_00c0);
    wb(OFF_CP[CH_RX], 1'b0, 32'h0, 4'hf);
    chk(rd, 32'h0341_0000);
    wb(OFF_WC[CH_TX], 1'b0, 32'h0, 4'hf);
    chk(rd, 32'h0);
    wb(5'h1c, 1'b0, 32'h0, 4'hf);
    chk(rd, 32'h0);
    chk({30'h0, tx, oe_n}, 32'h2);
    chk(vec, 32'h3000_002c);
    wb(OFF_CP[CH_TX], 1'b1, 32'hffff_02c0, 4'hf);
    wb(OFF_CP[CH_TX], 1'b0, 32'h0, 4'hf);
    chk(rd, 32'h03ff_02c0);
    wb(OFF_CP[CH_TX], 1'b1, 32'h0000_0240, 4'h3);
    wb(OFF_STAT, 1'b0, 32'h0, 4'hf);
    chk({31'h0, tx}, 32'h0);
    wb(OFF_CP[CH_TX], 1'b1, 32'h0000_02c0, 4'h3);
    wb(OFF_STAT, 1'b0, 32'h0, 4'hf);
    chk({31'h0, tx}, 32'h1);
    wb(OFF_CFG, 1'b1, 32'h0000_001f, 4'hf);
    for (int c = 0; c < 2; c++) begin
      d = 4 * (4 << c);
      wb(OFF_CP[CH_TX], 1'b1, {16'h0004, 16'h03c0 | 16'(c)}, 4'hf);
      fork
        rem.take(d, got, ok);
        wb(OFF_TXD, 1'b1, {24'h0, tbyte[c]}, 4'h1);
      join
      chk({23'h0, ok, got}, {23'h0, 1'b1, tbyte[c]});
      poll(9, 1'b0);
      chk({31'h0, tx}, 32'h1);
      wb(OFF_CP[CH_TX], 1'b0, 32'h0, 4'hf);
      chk(rd & 32'h0000_0088, 32'h0000_0080);
      chk({31'h0, firq}, 32'h1);
      wb(OFF_STAT, 1'b0, 32'h0, 4'hf);
      chk(rd & 32'h0000_1000, 32'h0000_1000);
      wb(OFF_STAT, 1'b1, 32'h0000_ff00, 4'h2);
      wb(OFF_STAT, 1'b0, 32'h0, 4'hf);
      chk({31'h0, firq}, 32'h0);
    end
    wb(OFF_WC[CH_TX], 1'b1, 32'h0000_0002, 4'h3);
    wb(OFF_WC[CH_TX], 1'b0, 32'h0, 4'hf);
    chk(rd & 32'h0000_ffff, 32'h0000_0002);
    wb(OFF_CP[CH_RX], 1'b1, 32'h0004_0300, 4'hf);
    rem.send(8'h5a, 16, 0, 1'b1);
    poll(8, 1'b1);
    chk(rd & 32'h0000_29ff, 32'h0000_295a);
    chk({31'h0, firq}, 32'h1);
    wb(OFF_STAT, 1'b1, 32'h0000_ff00, 4'h2);
    rem.send(8'h00, 16, 3, 1'b1);
    poll(15, 1'b1);
    chk(rd & 32'h0000_c100, 32'h0000_8000);
    wb(OFF_STAT, 1'b1, 32'h0000_ff00, 4'h2);
    rem.send(8'h00, 16, 0, 1'b0);
    poll(14, 1'b1);
    chk(rd & 32'h0000_4100, 32'h0000_4000);
    wb(OFF_STAT, 1'b1, 32'h0000_ff00, 4'h2);
    wb(OFF_CP[CH_TX], 1'b1, 32'h0004_03c0, 4'hf);
    fork
      wb(OFF_TXD, 1'b1, 32'h0000_00ff, 4'h1);
      begin
        repeat (20) @(posedge clk_i);
        rem.send(8'h33, 16, 0, 1'b1);
      end
    join
    poll(9, 1'b0);
    chk(rd & 32'h0000_0500, 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
